// [bench/iuvfr_monitor.sv]
// checker for the fault response core
// assumes it is bound to iuvfr_core
module iuvfr_monitor
  import iuvfr_pkg::*;
#(parameter int CYCLES_PER_MS = 10) (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [15:0] lockout_strap_threshold,
  input wire iuvfr_cmd_t  cmd,
  input wire logic        clear_faults,
  input wire logic        below_fault_threshold,
  input wire logic        above_warn_threshold,
  input wire logic        enable_request,
  input wire logic        other_fault_shutdown,
  input wire logic [15:0] rsp_rdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] fault_threshold_value,
  input wire logic        output_enable,
  input wire logic        alert_output_line_n,
  input wire logic        uv_fault_status,
  input wire logic        restart_attempt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // cycles since the last attempt, parked high after reset
  // ----------------------------------------------------------------
  // react shadows the reaction byte from the writes seen on cmd; owed is
  // set by a fault in run and dropped by the next attempt or a shutdown,
  // so only restarts that the retry delay governs are timed
  int         gap;
  int         next_gap;
  logic [7:0] react;
  logic [7:0] next_react;
  logic       owed;
  logic       next_owed;
  always_comb begin
    next_gap = (gap < 1000000) ? gap + 1 : gap;
    if (restart_attempt) next_gap = 0;
    next_react = react;
    if (cmd.valid && cmd.write && cmd.code == 8'h5A) begin
      next_react = cmd.wdata[7:0];
    end
    next_owed = owed;
    if (restart_attempt || !enable_request || other_fault_shutdown) begin
      next_owed = 1'b0;
    end
    if (output_enable && below_fault_threshold) next_owed = 1'b1;
    if (!reset_n) begin
      next_gap   = 1000000;
      next_react = 8'hBF;
      next_owed  = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    gap   <= next_gap;
    react <= next_react;
    owed  <= next_owed;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_hit;
    output_enable && below_fault_threshold;
  endsequence
  sequence s_retry_start;
    restart_attempt && owed && react[7:6] == 2'h2 && react[5:3] == 3'h7;
  endsequence
  rsp_pulse_a: assert property (cmd.valid |=> rsp_valid)
    else $error("no reply");
  rsp_quiet_a: assert property (!cmd.valid |=> !rsp_valid)
    else $error("stray reply");
  wr_reply_a: assert property (cmd.valid && cmd.write |=> rsp_rdata == 0)
    else $error("write reply not zero");
  thr_write_a: assert property (
    cmd.valid && cmd.write && cmd.code == 8'h59 |=>
    fault_threshold_value == $past(cmd.wdata)) else $error("thr write");
  alert_tie_a: assert property (alert_output_line_n == !uv_fault_status)
    else $error("alert differs from status");
  fault_hit_a: assert property (
    s_hit |=> uv_fault_status && !output_enable)
    else $error("fault missed");
  status_hold_a: assert property (
    uv_fault_status && !clear_faults |=> uv_fault_status)
    else $error("status dropped");
  status_clr_a: assert property (
    clear_faults && !below_fault_threshold |=> !uv_fault_status)
    else $error("status not cleared");
  off_cmd_a: assert property (
    !enable_request || other_fault_shutdown |=> !output_enable)
    else $error("output on while commanded off");
  low_stay_a: assert property (
    uv_fault_status && !output_enable && below_fault_threshold |=>
    !output_enable) else $error("output on during fault");
  retry_gap_a: assert property (
    s_retry_start |->
    gap + 1 >= (int'(react[2:0]) + 1) * 35 * CYCLES_PER_MS)
    else $error("attempts too close");
endmodule : iuvfr_monitor

// [bench/iuvfr_supply_model.sv]
// supply and comparator model for the fault response core
// assumes the bench sets the input level in millivolts
module iuvfr_supply_model #(
  parameter int FAULT_MV = 4000,
  parameter int WARN_MV  = 4400
) (
  input  wire logic [15:0] level_mv,
  output logic             below_fault,
  output logic             above_warn
);
  timeunit 1ns;
  timeprecision 1ps;
  // warn sits above fault, so a dip must recover past a margin
  assign below_fault = level_mv < FAULT_MV;
  assign above_warn  = level_mv > WARN_MV;
endmodule : iuvfr_supply_model

// [bench/iuvfr_test.sv]
// self-checking bench for the fault response core
// assumes core, supply model and checker compiled before it
module iuvfr_test;
  import iuvfr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 10;
  localparam logic [15:0] V_OK = 16'h1388, V_LOW = 16'h0BB8;
  localparam logic [15:0] V_MID = 16'h1068;
  `define CHK(what, exp, got) begin n_compared++; \
    if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %s exp %h got %h", what, exp, got); end end
  logic clk = 0, reset_n = 0, clear_faults = 0, en = 0, oth = 0, ok;
  logic [15:0] strap = 0, input_supply_voltage = V_OK, rdat, thr;
  logic below, above, rv, oe, al_n, st, att;
  iuvfr_cmd_t cmd = '0;
  int n_errors = 0, n_compared = 0, cyc = 0, seed = 32'h4935, n;
  int m_thr, m_react, dl[3] = '{0, 7, 0};
  logic [15:0] lc[3] = '{16'h0080, 16'h0040, 16'h0098};
  iuvfr_core #(.CYCLES_PER_MS(CPM)) i_iuvfr_core (.clk, .reset_n,
    .lockout_strap_threshold(strap), .cmd, .clear_faults,
    .below_fault_threshold(below), .above_warn_threshold(above),
    .enable_request(en), .other_fault_shutdown(oth), .rsp_rdata(rdat),
    .rsp_valid(rv), .fault_threshold_value(thr), .output_enable(oe),
    .alert_output_line_n(al_n), .uv_fault_status(st),
    .restart_attempt(att));
  iuvfr_supply_model i_iuvfr_supply_model (.level_mv(input_supply_voltage),
    .below_fault(below), .above_warn(above));
  always #20 clk = ~clk;
  // a hang counts as a mismatch, then the normal report runs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk);
    #2;
  endtask : tick
  task automatic acc(input logic w, input logic [7:0] c,
                     input logic [15:0] d, input logic [15:0] e);
    cmd = '{1'b1, w, c, d};
    tick();
    cmd.valid = 1'b0;
    `CHK("reply", 1'b1, rv)
    if (!w) `CHK("read", e, rdat)
    // one idle edge, so a following access never re-raises valid at once
    tick();
  endtask : acc
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    acc(1'b1, c, d, 16'h0000);
    if (c == 8'h59) m_thr = d;
    if (c == 8'h5A) m_react = d[7:0];
  endtask : wr
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    acc(1'b0, c, 16'h0000, e);
  endtask : rdchk
  task automatic wait_for(input logic use_att, input int lim);
    n = 0;
    while ((use_att ? att : oe) !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
  endtask : wait_for
  task automatic hit();
    input_supply_voltage = V_LOW;
    tick(2);
    `CHK("status", 1'b1, st)
    `CHK("alert", 1'b0, al_n)
    `CHK("off", 1'b0, oe)
  endtask : hit
  task automatic clr();
    clear_faults = 1'b1;
    tick();
    clear_faults = 1'b0;
    tick();
    `CHK("cleared", 1'b0, st)
  endtask : clr
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    strap = 16'($random(seed));
    dl[2] = $unsigned($random(seed)) % 8;
    tick(12);
    reset_n = 1'b1;
    m_thr = strap;
    m_react = 8'hBF;
    `CHK("thr", strap, thr)
    rdchk(8'h59, strap);
    rdchk(8'h5A, 16'(m_react));
    wr(8'h5B, 16'hFFFF);
    rdchk(8'h5B, 16'h0000);
    wr(8'h59, 16'($random(seed)));
    rdchk(8'h59, 16'(m_thr));
    $display("registers done");
    en = 1'b1;
    wait_for(1'b0, 50);
    `CHK("start", 1'b1, oe)
    foreach (dl[i]) begin
      wr(8'h5A, 16'h00B8 | 16'(dl[i]));
      hit();
      input_supply_voltage = V_OK;
      wait_for(1'b1, 4000);
      `CHK("attempt", 1'b1, att)
      hit();
      input_supply_voltage = V_OK;
      wait_for(1'b1, 4000);
      ok = (n + 2 >= (dl[i] + 1) * 35 * CPM)
        && (n + 2 <= (dl[i] + 1) * 35 * CPM + CPM + 1);
      `CHK("gap", 1'b1, ok)
      `CHK("sticky", 1'b1, st)
      clr();
    end
    $display("retry done");
    wr(8'h5A, 16'h00C0);
    hit();
    input_supply_voltage = V_MID;
    tick(30);
    `CHK("hold", 1'b0, oe)
    input_supply_voltage = V_OK;
    tick(3);
    `CHK("resume", 1'b1, oe)
    clr();
    $display("hold done");
    foreach (lc[i]) begin
      wr(8'h5A, lc[i]);
      rdchk(8'h5A, 16'(m_react));
      hit();
      input_supply_voltage = V_OK;
      tick(60);
      `CHK("latched", 1'b0, oe)
      clr();
      wait_for(1'b0, 10);
      `CHK("relaunch", 1'b1, oe)
    end
    $display("latch done");
    en = 1'b0;
    tick(2);
    `CHK("pin off", 1'b0, oe)
    en = 1'b1;
    wait_for(1'b0, 10);
    `CHK("pin on", 1'b1, oe)
    oth = 1'b1;
    tick(2);
    `CHK("other off", 1'b0, oe)
    $display("shutdown done");
    end_sim();
  end
endmodule : iuvfr_test

bind iuvfr_core iuvfr_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) i_mon (
  .clk, .reset_n, .lockout_strap_threshold, .cmd, .clear_faults,
  .below_fault_threshold, .above_warn_threshold, .enable_request,
  .other_fault_shutdown, .rsp_rdata, .rsp_valid, .fault_threshold_value,
  .output_enable, .alert_output_line_n, .uv_fault_status,
  .restart_attempt);

// [rtl/iuvfr_core.sv]
// input undervoltage fault response: threshold and reaction registers,
// fault status, alert line and the restart sequencer
// assumes an outside comparator reports the input against the fault and
// warning thresholds, and a command decoder delivers register accesses
//
// Behaviour
// - fault threshold is one 16-bit read-write exponent-mantissa word.
// - threshold loads from the lockout strap value at reset.
// - reaction byte is read-write, resets to continuous retry, longest delay.
// - each fault pulls alert low and sets status until clear-faults.
// - response code 10 disables output then follows the retry field.
// - response code 11 holds output off until input rises above warning.
// - retry code 000 keeps output off until faults are cleared.
// - retry code 111 restarts until disabled, unpowered or other fault.
// - continuous retry starts an attempt only once input is above warning.
// - retry interval is delay field plus one times 35 ms.
// - interval runs from one attempt start to the next.
// - a fault counts as gone only once input rises above warning.
`include "iuvfr_defines.svh"

module iuvfr_core
  import iuvfr_pkg::*;
#(
  parameter int CYCLES_PER_MS = `IUVFR_CYCLES_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] lockout_strap_threshold,
  input  wire iuvfr_cmd_t  cmd,
  input  wire logic        clear_faults,
  input  wire logic        below_fault_threshold,
  input  wire logic        above_warn_threshold,
  input  wire logic        enable_request,
  input  wire logic        other_fault_shutdown,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_valid,
  output logic [15:0]      fault_threshold_value,
  output logic             output_enable,
  output logic             alert_output_line_n,
  output logic             uv_fault_status,
  output logic             restart_attempt
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]     threshold;
  iuvfr_reaction_t reaction;
  logic [15:0]     next_threshold;
  iuvfr_reaction_t next_reaction;
  logic [15:0]     next_rsp_rdata;
  logic            next_rsp_valid;

  always_comb begin
    next_threshold = threshold;
    next_reaction  = reaction;
    next_rsp_rdata = 16'h0000;
    next_rsp_valid = cmd.valid;
    if (cmd.valid && cmd.write) begin
      if (cmd.code == `IUVFR_CMD_THRESHOLD) begin
        next_threshold = cmd.wdata;
      end
      if (cmd.code == `IUVFR_CMD_REACTION) begin
        next_reaction = cmd.wdata[7:0];
      end
    end
    if (cmd.valid && !cmd.write) begin
      // unmapped codes read as zero
      unique case (cmd.code)
        `IUVFR_CMD_THRESHOLD: next_rsp_rdata = threshold;
        `IUVFR_CMD_REACTION:  next_rsp_rdata = {8'h00, reaction};
        default:              next_rsp_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // strap is a steady level, so the synchronous reset may sample it
      threshold <= lockout_strap_threshold;
      reaction  <= `IUVFR_REACTION_RESET;
      rsp_rdata <= 16'h0000;
      rsp_valid <= 1'b0;
    end else begin
      threshold <= next_threshold;
      reaction  <= next_reaction;
      rsp_rdata <= next_rsp_rdata;
      rsp_valid <= next_rsp_valid;
    end
  end

  assign fault_threshold_value = threshold;

  // ----------------------------------------------------------------
  // decode of the reaction byte
  // ----------------------------------------------------------------
  logic       mode_hold;
  logic       mode_retry;
  logic [8:0] interval_ms;

  always_comb begin
    mode_hold  = (reaction.resp == `IUVFR_RESP_HOLD);
    // any other combination falls back to latched shutdown
    mode_retry = (reaction.resp == `IUVFR_RESP_RETRY) &&
                 (reaction.retry == `IUVFR_RETRY_FOREVER);
    interval_ms = 9'(({6'h00, reaction.delay} + 9'h001) *
                     9'(`IUVFR_RETRY_UNIT_MS));
  end

  // ----------------------------------------------------------------
  // millisecond timer since the last attempt
  // ----------------------------------------------------------------
  logic                 tick;
  logic                 attempt;
  logic [`IUVFR_MS_W-1:0] ms_count;
  logic [`IUVFR_MS_W-1:0] next_ms_count;

  iuvfr_ms_tick #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .restart (attempt),
    .tick    (tick)
  );

  always_comb begin
    next_ms_count = ms_count;
    if (attempt) begin
      next_ms_count = '0;
    end else if (tick && ms_count != `IUVFR_MS_MAX) begin
      next_ms_count = ms_count + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // fault tracking, status and sequencer
  // ----------------------------------------------------------------
  iuvfr_state_t state;
  iuvfr_state_t next_state;
  logic         uv_active;
  logic         next_uv_active;
  logic         fault_event;
  logic         next_status;
  logic         next_output_enable;

  always_comb begin
    fault_event = below_fault_threshold && !uv_active;
    // the fault only goes away above the warning level
    next_uv_active = uv_active;
    if (below_fault_threshold) begin
      next_uv_active = 1'b1;
    end else if (above_warn_threshold) begin
      next_uv_active = 1'b0;
    end
    // a new fault in the clearing cycle keeps the flag set
    next_status = (uv_fault_status && !clear_faults) || fault_event;
    next_state = state;
    attempt    = 1'b0;
    unique case (state)
      IUVFR_IDLE: begin
        if (enable_request && !other_fault_shutdown && !uv_active &&
            !below_fault_threshold) begin
          next_state = IUVFR_RUN;
          attempt    = 1'b1;
        end
      end
      IUVFR_RUN: begin
        if (below_fault_threshold) begin
          if (mode_hold) begin
            next_state = IUVFR_HOLD;
          end else if (mode_retry) begin
            next_state = IUVFR_RETRY_WAIT;
          end else begin
            next_state = IUVFR_LATCHED;
          end
        end
      end
      IUVFR_LATCHED: begin
        if (clear_faults) begin
          next_state = IUVFR_IDLE;
        end
      end
      IUVFR_HOLD: begin
        if (!uv_active) begin
          next_state = IUVFR_RUN;
          attempt    = 1'b1;
        end
      end
      IUVFR_RETRY_WAIT: begin
        if (!uv_active && ms_count >= interval_ms) begin
          next_state = IUVFR_RUN;
          attempt    = 1'b1;
        end
      end
    endcase
    // commanded off or forced down stops any pending retry
    if (!enable_request || other_fault_shutdown) begin
      next_state = IUVFR_IDLE;
      attempt    = 1'b0;
    end
    next_output_enable = (next_state == IUVFR_RUN);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state               <= IUVFR_IDLE;
      uv_active           <= 1'b0;
      uv_fault_status     <= 1'b0;
      alert_output_line_n <= 1'b1;
      output_enable       <= 1'b0;
      restart_attempt     <= 1'b0;
      // saturated so the first start is not delayed
      ms_count            <= `IUVFR_MS_MAX;
    end else begin
      state               <= next_state;
      uv_active           <= next_uv_active;
      uv_fault_status     <= next_status;
      alert_output_line_n <= !next_status;
      output_enable       <= next_output_enable;
      restart_attempt     <= attempt;
      ms_count            <= next_ms_count;
    end
  end

endmodule : iuvfr_core

// [rtl/iuvfr_ms_tick.sv]
// millisecond tick divider with a synchronous restart
// assumes one clock and a synchronous active-low reset
`include "iuvfr_defines.svh"

module iuvfr_ms_tick #(
  parameter int CYCLES_PER_MS = `IUVFR_CYCLES_PER_MS
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic restart,
  output logic      tick
);
  localparam int CW = $clog2(CYCLES_PER_MS + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    next_tick  = 1'b0;
    next_count = count + 1'b1;
    if (restart) begin
      next_count = '0;
    end else if (count == CW'(CYCLES_PER_MS - 1)) begin
      next_count = '0;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule : iuvfr_ms_tick

// [shared/iuvfr_defines.svh]
// named offsets, reset values and timing figures for the input
// undervoltage fault response block
// assumes nothing beyond being included by its bare name
`ifndef IUVFR_DEFINES_SVH
`define IUVFR_DEFINES_SVH

// ----------------------------------------------------------------
// command codes of the two registers
// ----------------------------------------------------------------
`define IUVFR_CMD_THRESHOLD     8'h59
`define IUVFR_CMD_REACTION      8'h5A

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define IUVFR_REACTION_RESET    8'hBF
`define IUVFR_RESP_HI           7
`define IUVFR_RESP_LO           6
`define IUVFR_RETRY_HI          5
`define IUVFR_RETRY_LO          3
`define IUVFR_DELAY_HI          2
`define IUVFR_DELAY_LO          0
`define IUVFR_RESP_RETRY        2'h2
`define IUVFR_RESP_HOLD         2'h3
`define IUVFR_RETRY_NONE        3'h0
`define IUVFR_RETRY_FOREVER     3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IUVFR_CLK_PERIOD_NS     40
`define IUVFR_MS_NS             1000000
`define IUVFR_CYCLES_PER_MS     (`IUVFR_MS_NS / `IUVFR_CLK_PERIOD_NS)
`define IUVFR_RETRY_UNIT_MS     35
`define IUVFR_MS_W              9
`define IUVFR_MS_MAX            9'h1FF

`endif

// [shared/iuvfr_pkg.sv]
// types shared by the input undervoltage fault response block
// assumes the defines header sits beside it
`include "iuvfr_defines.svh"

package iuvfr_pkg;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } iuvfr_reaction_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } iuvfr_cmd_t;

  typedef enum logic [2:0] {
    IUVFR_IDLE,
    IUVFR_RUN,
    IUVFR_LATCHED,
    IUVFR_HOLD,
    IUVFR_RETRY_WAIT
  } iuvfr_state_t;

endpackage : iuvfr_pkg
